// ==== hdl/lf_carrier_pkg.sv ====
// Package of register layout, codes and timing counts for the carrier qualify control.
package lf_carrier_pkg;
    // ********************************************************************
    // Register map.
    // ********************************************************************
    localparam logic [3:0] ctl3_addr        = 4'h0;
    localparam logic [3:0] status_addr      = 4'h4;
    localparam logic [3:0] aux_addr         = 4'h8;
    localparam int         det_out_pos      = 7;
    localparam int         toggle_pos       = 6;
    localparam int         preamble_hi      = 5;
    localparam int         preamble_lo      = 4;
    localparam int         qual_hi          = 3;
    localparam int         qual_lo          = 0;
    localparam int         status_cdf_pos   = 0;
    localparam int         status_valid_pos = 1;
    localparam int         status_mode_pos  = 2;
    localparam int         status_chain_pos = 3;
    localparam int         status_az_pos    = 4;
    localparam int         aux_irqen_pos    = 0;
    localparam int         aux_mode_pos     = 1;
    localparam int         aux_decoder_enable_pos    = 2;
    localparam int         aux_start_pos    = 3;
    localparam logic [7:0] ctl3_reset       = 8'h00;
    localparam logic [2:0] aux_reset        = 3'h0;
    // ********************************************************************
    // Qualify counts and auto-zero timing.
    // ********************************************************************
    localparam logic [1:0]  preamble_factory = 2'h0;
    localparam logic [10:0] base_periods     = 11'h008;
    localparam int          clk_mhz          = 40;
    localparam int          autozero_us      = 64;
    localparam int          autozero_period_us = 1000;
    localparam int          autozero_cycles  = autozero_us * clk_mhz;
    localparam int          az_period_cycles = autozero_period_us * clk_mhz;
    localparam logic [10:0] az_min_periods   = 11'h080;
    localparam logic [3:0]  qual_long_code   = 4'h8;
    typedef enum logic [2:0] {
        st_idle     = 3'b001,
        st_qualify  = 3'b010,
        st_valid    = 3'b100
    } qual_state_t;
endpackage

// ==== hdl/lf_carrier_qualify_ctrl.sv ====
// Carrier qualify control register and logic of the low-frequency wake-up receiver.
//
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/10ps
// Overview of operation
// - Bit 7 mirrors the live slicer output.
// - Bit 7 ignores writes and every reset.
// - Toggle enable inverts mode each sampling sequence.
// - First toggled sequence uses current mode select.
// - Bits 5:4 select 6T, 7.5T, 9T preamble.
// - Carrier mode qualify sets flag, optional interrupt.
// - Data mode keeps receive chain off until qualified.
// - After validation data mode ignores qualify time.
// - Receiver reset clears qualify time field.
// - Codes 0-7: carrier periods 8 doubling to 1024.
// - Codes 0-7: data mode needs 8 periods.
// - Qualify counts carrier periods, not local clocks.
// - Codes 8-15: both modes 8 doubling to 1024.
// - Data mode suppresses interrupt unless decoder disabled.
// - Long qualify: 64 us auto-zero every 1 ms.
module lf_carrier_qualify_ctrl
    import lf_carrier_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_rstn,
    input  wire logic        i_slicer_out,
    input  wire logic        i_carrier_period,
    input  wire logic        i_sampling_on,
    input  wire logic        i_sampling_done,
    input  wire logic        i_rx_reset,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [3:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    output logic             o_carrier_irq,
    output logic             o_chain_power,
    output logic             o_carrier_mode,
    output logic             o_autozero,
    output logic      [1:0]  o_preamble_len
);
    import lf_carrier_pkg::*;

    // ********************************************************************
    // Reset release and qualify count decode.
    // ********************************************************************
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Returns the carrier periods needed for a code in the given mode.
    function automatic logic [10:0] periods_needed(input logic [3:0] code, input logic carrier);
        logic [10:0] n;
        n = base_periods << code[2:0];
        if (!carrier && !code[3]) begin
            n = base_periods;
        end
        return n;
    endfunction

    // ********************************************************************
    // Register file.
    // ********************************************************************
    logic       toggle_reg, toggle_next;
    logic [1:0] preamble_reg, preamble_next;
    logic [3:0] qual_reg, qual_next;
    logic [2:0] aux_reg, aux_next;
    logic       mode_reg, mode_next;
    logic       cdf_reg, cdf_next;
    logic       ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic       wr_hit, rd_hit, cdf_set;
    logic       slicer_reg;
    qual_state_t st_reg, st_next;
    logic       chain_reg, chain_next;
    logic       az_reg, az_next;
    logic       irq_reg, irq_next;

    assign wr_hit = i_wb_cyc && i_wb_stb && i_wb_we && !ack_reg;
    assign rd_hit = i_wb_cyc && i_wb_stb && !i_wb_we && !ack_reg;

    // The slicer copy has no reset so that no reset ever disturbs it.
    always_ff @(posedge i_mclk) begin
        slicer_reg <= i_slicer_out;
    end

    always_comb begin
        toggle_next   = toggle_reg;
        preamble_next = preamble_reg;
        qual_next     = qual_reg;
        aux_next      = aux_reg;
        mode_next     = mode_reg;
        cdf_next      = cdf_reg;
        ack_next      = rd_hit || wr_hit;
        rdat_next     = rdat_reg;
        if (wr_hit && i_wb_sel[0]) begin
            unique case (i_wb_adr)
                ctl3_addr: begin
                    toggle_next   = i_wb_dat[toggle_pos];
                    preamble_next = i_wb_dat[preamble_hi:preamble_lo];
                    qual_next     = i_wb_dat[qual_hi:qual_lo];
                end
                status_addr: begin
                    if (i_wb_dat[status_cdf_pos]) begin
                        cdf_next = 1'b0;
                    end
                end
                aux_addr: begin
                    aux_next  = i_wb_dat[aux_decoder_enable_pos:aux_irqen_pos];
                    mode_next = i_wb_dat[aux_mode_pos];
                end
                default: begin
                end
            endcase
        end
        // Mode flips on each sampling-done strobe; the first sequence keeps the held mode.
        if (toggle_reg && i_sampling_done) begin
            mode_next = ~mode_reg;
        end
        if (cdf_set) begin
            cdf_next = 1'b1;
        end
        if (i_rx_reset) begin
            qual_next = 4'h0;
        end
        if (rd_hit) begin
            rdat_next = 32'h0000_0000;
            unique case (i_wb_adr)
                ctl3_addr: rdat_next[7:0] = {slicer_reg, toggle_reg, preamble_reg, qual_reg};
                status_addr: begin
                    rdat_next[status_cdf_pos]   = cdf_reg;
                    rdat_next[status_valid_pos] = st_reg == st_valid;
                    rdat_next[status_mode_pos]  = mode_reg;
                    rdat_next[status_chain_pos] = chain_reg;
                    rdat_next[status_az_pos]    = az_reg;
                end
                aux_addr: rdat_next[aux_decoder_enable_pos:aux_irqen_pos] = {aux_reg[2], mode_reg, aux_reg[0]};
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            toggle_reg   <= ctl3_reset[toggle_pos];
            preamble_reg <= ctl3_reset[preamble_hi:preamble_lo];
            qual_reg     <= ctl3_reset[qual_hi:qual_lo];
            aux_reg      <= aux_reset;
            mode_reg     <= 1'b0;
            cdf_reg      <= 1'b0;
            ack_reg      <= 1'b0;
            rdat_reg     <= 32'h0000_0000;
        end else begin
            toggle_reg   <= toggle_next;
            preamble_reg <= preamble_next;
            qual_reg     <= qual_next;
            aux_reg      <= aux_next;
            mode_reg     <= mode_next;
            cdf_reg      <= cdf_next;
            ack_reg      <= ack_next;
            rdat_reg     <= rdat_next;
        end
    end

    // ********************************************************************
    // Carrier qualification.
    // ********************************************************************
    logic [10:0] cnt_reg, cnt_next;
    logic [10:0] need;
    logic        az_window, long_qual;
    logic [15:0] az_cnt_reg, az_cnt_next;
    logic        az_held_reg, az_held_next;

    assign need      = periods_needed(qual_reg, mode_reg);
    assign long_qual = need >= az_min_periods;
    assign az_window = az_cnt_reg < 16'(autozero_cycles);
    assign cdf_set   = st_reg == st_qualify && st_next == st_valid && mode_reg;

    always_comb begin
        st_next      = st_reg;
        cnt_next     = cnt_reg;
        chain_next   = chain_reg;
        az_next      = 1'b0;
        az_held_next = az_held_reg;
        irq_next     = 1'b0;
        az_cnt_next  = (az_cnt_reg == 16'(az_period_cycles - 1)) ? 16'h0000 : az_cnt_reg + 16'h0001;
        unique case (st_reg)
            st_idle: begin
                cnt_next   = 11'h000;
                chain_next = 1'b0;
                az_cnt_next = 16'(autozero_cycles);
                if (i_sampling_on) begin
                    st_next = st_qualify;
                end
            end
            st_qualify: begin
                if (long_qual && az_window) begin
                    az_next      = 1'b1;
                    az_held_next = 1'b1;
                end else if (az_held_reg) begin
                    az_held_next = 1'b0;
                    if (!slicer_reg) begin
                        cnt_next = 11'h000;
                    end
                end else if (!slicer_reg) begin
                    cnt_next = 11'h000;
                end else if (i_carrier_period) begin
                    cnt_next = cnt_reg + 11'h001;
                end
                if (cnt_reg >= need) begin
                    st_next = st_valid;
                end
                if (i_sampling_done) begin
                    st_next = st_idle;
                end
            end
            st_valid: begin
                // The qualify code no longer matters once validated.
                chain_next = !mode_reg;
                if (i_sampling_done) begin
                    st_next = st_idle;
                end
            end
            default: st_next = st_idle;
        endcase
        irq_next = cdf_reg && aux_reg[aux_irqen_pos] && (mode_reg || !aux_reg[aux_decoder_enable_pos]);
        if (i_rx_reset) begin
            st_next = st_idle;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg      <= st_idle;
            cnt_reg     <= 11'h000;
            chain_reg   <= 1'b0;
            az_reg      <= 1'b0;
            az_held_reg <= 1'b0;
            irq_reg     <= 1'b0;
            az_cnt_reg  <= 16'h0000;
        end else begin
            st_reg      <= st_next;
            cnt_reg     <= cnt_next;
            chain_reg   <= chain_next;
            az_reg      <= az_next;
            az_held_reg <= az_held_next;
            irq_reg     <= irq_next;
            az_cnt_reg  <= az_cnt_next;
        end
    end

    assign o_wb_dat       = rdat_reg;
    assign o_wb_ack       = ack_reg;
    assign o_carrier_irq  = irq_reg;
    assign o_chain_power  = chain_reg;
    assign o_carrier_mode = mode_reg;
    assign o_autozero     = az_reg;
    assign o_preamble_len = preamble_reg;

    // ********************************************************************
    // Checks.
    // ********************************************************************
    a_chain_off_qual: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (st_reg != st_valid) |-> ##1 !chain_reg || st_reg == st_valid)
        else $error("Receive chain powered before carrier validated.");
    a_mode_toggle: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (toggle_reg && i_sampling_done && !wr_hit) |=> mode_reg != $past(mode_reg))
        else $error("Carrier mode did not toggle.");
    a_mode_fixed: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (!toggle_reg && !(wr_hit && i_wb_adr == aux_addr)) |=> $stable(mode_reg))
        else $error("Carrier mode changed without toggle.");
    a_qual_clear: assert property (@(posedge i_mclk) disable iff (!rst_n)
        i_rx_reset |=> qual_reg == 4'h0)
        else $error("Qualify time not cleared by receiver reset.");
    a_flag_set: assert property (@(posedge i_mclk) disable iff (!rst_n)
        cdf_set |=> cdf_reg)
        else $error("Carrier flag not set on qualify.");
    a_data_irq: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (!mode_reg && aux_reg[aux_decoder_enable_pos]) |=> !irq_reg)
        else $error("Interrupt raised in data mode with decoder on.");
    a_drop_restart: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (st_reg == st_qualify && !slicer_reg && !az_next && !az_held_reg) |=> cnt_reg == 11'h000)
        else $error("Counter kept running after carrier drop.");
    a_data_need: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (!mode_reg && !qual_reg[3]) |-> need == base_periods)
        else $error("Data mode count not fixed at eight.");
endmodule // lf_carrier_qualify_ctrl

// ==== verif/lf_carrier_qualify_ctrl_bench.sv ====
// Self-checking bench for the carrier qualify control block.
`timescale 1ns/10ps
module lf_carrier_qualify_ctrl_bench;
    import lf_carrier_pkg::*;
    logic        i_mclk = 0, i_rstn = 0, i_sampling_on = 0, i_sampling_done = 0, i_rx_reset = 0;
    logic        i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0, slicer, period;
    logic [3:0]  i_wb_adr = 4'h0, i_wb_sel = 4'h1;
    logic [31:0] i_wb_dat = 32'h0000_0000, o_wb_dat, rd;
    logic        o_wb_ack, o_carrier_irq, o_chain_power, o_carrier_mode, o_autozero;
    logic [1:0]  o_preamble_len;
    int          num_errors = 0, total_checks = 0, need;
    always #12.5 i_mclk = ~i_mclk;
    lf_detector_model fe (.i_mclk(i_mclk), .o_slicer_out(slicer), .o_carrier_period(period));
    lf_carrier_qualify_ctrl uut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_slicer_out(slicer),
        .i_carrier_period(period), .i_sampling_on(i_sampling_on), .i_sampling_done(i_sampling_done),
        .i_rx_reset(i_rx_reset), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
        .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
        .o_wb_ack(o_wb_ack), .o_carrier_irq(o_carrier_irq), .o_chain_power(o_chain_power),
        .o_carrier_mode(o_carrier_mode), .o_autozero(o_autozero), .o_preamble_len(o_preamble_len));
    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d.", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // The request is held until ack is sampled high; a missing ack ends the run.
    task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] dat);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we  <= we;
        i_wb_adr <= adr;
        i_wb_dat <= {24'h00_0000, dat};
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 50);
        rd = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            wrap_up();
        end
    endtask
    // Qualification only runs between a sampling-on and a sampling-done strobe.
    task automatic strobe(input logic on);
        @(posedge i_mclk);
        if (on) i_sampling_on <= 1'b1;
        else i_sampling_done <= 1'b1;
        @(posedge i_mclk);
        i_sampling_on   <= 1'b0;
        i_sampling_done <= 1'b0;
    endtask
    task automatic seq_pulse(input logic exp);
        @(posedge i_mclk) i_sampling_on <= 1'b1;
        @(posedge i_mclk) i_sampling_on <= 1'b0;
        @(posedge i_mclk) check(o_carrier_mode, exp);
        i_sampling_done <= 1'b1;
        @(posedge i_mclk) i_sampling_done <= 1'b0;
        repeat (2) @(posedge i_mclk);
    endtask
    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic test_reg();
        wb(1'b0, ctl3_addr, 8'h00);
        check(rd, 32'h0000_0000);
        wb(1'b1, ctl3_addr, 8'hFA);
        wb(1'b0, ctl3_addr, 8'h00);
        check(rd[7:0], 8'h7A);
        i_rx_reset <= 1'b1;
        @(posedge i_mclk) i_rx_reset <= 1'b0;
        wb(1'b0, ctl3_addr, 8'h00);
        check(rd[3:0], 4'h0);
        fe.send(0, 3);
        wb(1'b0, ctl3_addr, 8'h00);
        check(rd[7], 1'b1);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_mclk);
        wb(1'b0, ctl3_addr, 8'h00);
        check(rd[7:0], 8'h80);
        fe.drop();
        for (int p = 1; p < 4; p++) begin
            wb(1'b1, ctl3_addr, 8'(p << 4));
            check(o_preamble_len, p[1:0]);
        end
        $display("Register test done.");
    endtask
    task automatic test_carrier();
        wb(1'b1, aux_addr, 8'h03);
        for (int c = 0; c < 3; c++) begin
            need = 8 << c;
            wb(1'b1, ctl3_addr, 8'(c));
            wb(1'b1, status_addr, 8'h01);
            strobe(1'b1);
            fe.send(need - 1, 2 + c);
            if (c == 0) begin
                fe.drop();
                fe.send(need - 1, 3);
            end
            wb(1'b0, status_addr, 8'h00);
            check(rd[status_cdf_pos], 1'b0);
            fe.send(1, 3);
            wb(1'b0, status_addr, 8'h00);
            check(rd[status_cdf_pos], 1'b1);
            check(o_carrier_irq, 1'b1);
            fe.drop();
            strobe(1'b0);
        end
        $display("Carrier mode test done.");
    endtask
    task automatic test_data();
        // The flag left set by the carrier test must be masked in data mode while decoding is on.
        wb(1'b1, aux_addr, 8'h05);
        @(posedge i_mclk);
        check(o_carrier_irq, 1'b0);
        wb(1'b1, aux_addr, 8'h01);
        @(posedge i_mclk);
        check(o_carrier_irq, 1'b1);
        wb(1'b1, aux_addr, 8'h05);
        for (int c = 3; c < 12; c += 6) begin
            need = (c < 8) ? 8 : 8 << (c - 8);
            wb(1'b1, ctl3_addr, 8'(c));
            wb(1'b1, status_addr, 8'h01);
            strobe(1'b1);
            fe.send(need - 1, 3);
            check(o_chain_power, 1'b0);
            fe.send(1, 3);
            check(o_chain_power, 1'b1);
            check(o_carrier_irq, 1'b0);
            wb(1'b1, ctl3_addr, 8'h0F);
            check(o_chain_power, 1'b1);
            fe.drop();
            strobe(1'b0);
        end
        $display("Data mode test done.");
    endtask
    task automatic test_autozero();
        int n;
        n = 0;
        wb(1'b1, aux_addr, 8'h02);
        wb(1'b1, ctl3_addr, 8'h04);
        strobe(1'b1);
        fe.send(0, 3);
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_autozero !== 1'b1 && n < 40000);
        if (n >= 40000) begin
            num_errors++;
            wrap_up();
        end
        n = 0;
        while (o_autozero === 1'b1 && n < 3000) begin
            @(posedge i_mclk);
            n++;
        end
        check(n, autozero_cycles);
        strobe(1'b0);
        fe.drop();
        $display("Auto-zero test done.");
    endtask
    task automatic test_toggle();
        wb(1'b1, aux_addr, 8'h02);
        wb(1'b1, ctl3_addr, 8'h40);
        for (int k = 0; k < 4; k++)
            seq_pulse(k[0] ? 1'b0 : 1'b1);
        wb(1'b1, ctl3_addr, 8'h00);
        seq_pulse(1'b1);
        seq_pulse(1'b1);
        $display("Mode toggle test done.");
    endtask
    initial begin
        repeat (10) @(posedge i_mclk);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_mclk);
        test_reg();
        test_carrier();
        test_data();
        test_toggle();
        test_autozero();
        wrap_up();
    end
endmodule // lf_carrier_qualify_ctrl_bench

// ==== verif/lf_detector_model.sv ====
// Behavioural model of the detector front end: slicer level and carrier period pulses.
`timescale 1ns/10ps
module lf_detector_model (
    input  wire logic i_mclk,
    output logic      o_slicer_out,
    output logic      o_carrier_period
);
    initial begin
        o_slicer_out     = 1'b0;
        o_carrier_period = 1'b0;
    end
    // ****************************************************************
    // Carrier bursts.
    // ****************************************************************
    // Periods come far faster than a real carrier so runs stay short; the block counts periods, not time.
    task automatic send(input int n, input int gap);
        @(posedge i_mclk) o_slicer_out <= 1'b1;
        repeat (n) begin
            repeat (gap) @(posedge i_mclk);
            o_carrier_period <= 1'b1;
            @(posedge i_mclk) o_carrier_period <= 1'b0;
        end
        repeat (4) @(posedge i_mclk);
    endtask
    task automatic drop();
        @(posedge i_mclk) o_slicer_out <= 1'b0;
        repeat (4) @(posedge i_mclk);
    endtask
endmodule // lf_detector_model
